// ---- design/iep_irq_ctrl.sv ----
// Notes on behaviour
// R1: global enable off blocks all but resume
// R2: global enable on, each source follows own enable
// R3: enable bit 6 gates serial 1 tx/rx
// R4: enable bit 5 gates timer 2 flags
// R5: enable bit 4 gates serial 0 tx/rx
// R6: enable bit 3 gates timer 1 overflow
// R7: enable bit 2 gates external pin 1
// R8: enable bit 1 gates timer 0 overflow
// R9: enable bit 0 gates external pin 0
// R10: priority bits 6..0 pick high or low group
// R11: priority bit 7, flag bit 3 read one
// R12: flag register bits 2..0 read zero
// R13: falling edge on pin 5 sets flag 7
// R14: software alone clears extended flags
// R15: software writing one raises the request
// R16: flag 6 from fifo engine or pin 4
// R17: pin 4 mode sets flag 6 on rise
// R18: two wire bus event sets flag 5
// R19: usb event sets flag 4
// R20: same group ties resolved by natural order
// R21: request needs flag, enable, global or resume
`timescale 1ns/1ps
`default_nettype none
// enable, priority and sticky flag logic in front of the core;
// requests are registered, so the core sees them one cycle after
// the state that caused them; the trade is one cycle of latency
// for a clean, glitch free request vector
module iep_irq_ctrl (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// special function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd,
	output logic      [7:0]  sfr_rdata,
	// peripheral flags, same clock
	input  wire logic        ext0_request_flag,
	input  wire logic        ext1_request_flag,
	input  wire logic        timer0_overflow_flag,
	input  wire logic        timer1_overflow_flag,
	input  wire logic        timer2_overflow_flag,
	input  wire logic        timer2_external_flag,
	input  wire logic        serial0_tx_flag,
	input  wire logic        serial0_rx_flag,
	input  wire logic        serial1_tx_flag,
	input  wire logic        serial1_rx_flag,
	// extended event sources, same clock
	input  wire logic        usb_event,
	input  wire logic        two_wire_bus_event,
	input  wire logic        fifo_engine_event,
	input  wire logic        resume_event,
	input  wire logic        ext4_pin_mode,
	// external pins, asynchronous
	input  wire logic        ext5_pin_n,
	input  wire logic        ext4_pin,
	input  wire logic        ext6_pin,
	// request towards the core
	output logic      [12:0] irq_pending,
	output logic             irq_valid,
	output logic      [3:0]  irq_index,
	output logic             irq_high_group,
	output logic             serial1_rate_double
);
	// one request bit per source; the bit index is its natural priority
	localparam int unsigned N = iep_pkg::SRC_N;

	// the request ports are sized by hand, so they must match the count
	generate
		if (N != $bits(irq_pending) || iep_pkg::EDGE_N != 3)
		begin : g_bad_count
			$error("iep_irq_ctrl source count does not fit its ports");
		end
	endgenerate

	// decode of one register address, used for writes; reads decode by case
	// full byte compare; a partial decode would alias registers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// lowest set index wins, used for both groups
	// the scan runs downwards so the lowest hit is written last
	function automatic logic [3:0] first_set(input logic [N-1:0] v);
		first_set = 4'h0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (v[i])
				first_set = 4'(i);
		end
	endfunction

	// all state of the controller
	typedef struct packed {
		// registers written by the core
		logic [7:0]   ie;        // interrupt_enable
		logic [6:0]   ip;        // interrupt_priority, writable bits
		// sticky extended flags, cleared only by software
		logic         ext5_flag; // ext5_edge_flag
		logic         ext4_flag; // fifo_or_ext4_flag
		logic         i2c_flag;  // two_wire_bus_flag
		logic         usb_flag;  // usb_event_flag
		// extended control fields
		logic         baud2;     // serial 1 rate doubler
		logic         res_en;    // resume enable
		logic         res_flag;  // resume flag
		logic         ext6_flag; // ext6 flag
		// extended enable and priority
		logic [4:0]   xen;       // extended_interrupt_enable bits
		logic [4:0]   xprio;     // extended_interrupt_priority bits
		// registered outputs
		logic [7:0]   rdata;     // read data, held until next read
		logic [N-1:0] pend;      // gated requests
		logic         valid;     // some request pending
		logic [3:0]   idx;       // winning source
		logic         high;      // winner is in the high group
	} iep_ctrl_s;

	iep_ctrl_s s_r;   // registered state
	iep_ctrl_s s_nxt; // next state

	// pin edge detection lives in the sync module
	// its fill counter also hides the levels present at reset
	iep_edge_if #(.N(iep_pkg::EDGE_N)) edges ();

	// pins gathered in channel order in one process, so the
	// interface vector has a single driver
	always_comb
	begin
		edges.pin                     = '0;
		edges.pin[iep_pkg::EDGE_EXT5] = ext5_pin_n;
		edges.pin[iep_pkg::EDGE_EXT4] = ext4_pin;
		edges.pin[iep_pkg::EDGE_EXT6] = ext6_pin;
	end

	iep_edge_sync #(.N(iep_pkg::EDGE_N)) u_edge (
		.clk  (clk),
		.rstn (rstn),
		.e    (edges.sync)
	);

	// hardware set terms of the sticky flags
	// all are one-cycle pulses already on the core clock
	logic         set_ext5;  // pin 5 falling edge
	logic         set_ext4;  // fifo engine or pin 4 rising edge
	logic         set_ext6;  // pin 6 rising edge
	// write strobes per register
	logic         wr_ie;
	logic         wr_ip;
	logic         wr_xf;
	logic         wr_xc;
	logic         wr_xe;
	logic         wr_xp;
	// source vectors in natural order
	// every vector below shares the same source index
	logic [N-1:0] src_flag;  // raw flags
	logic [N-1:0] src_en;    // individual enables
	logic [N-1:0] src_gate;  // global gate per source
	logic [N-1:0] src_high;  // high group membership
	logic [N-1:0] req;       // gated requests
	logic [N-1:0] req_hi;    // requests in high group
	logic [N-1:0] req_lo;    // requests in low group

	// edge and event qualification
	always_comb
	begin
		// pin 5 is active low, so its falling edge is the event
		set_ext5 = edges.fall[iep_pkg::EDGE_EXT5]; // see R13
		// pin 4 only counts when selected; else fifo engine drives
		if (ext4_pin_mode)
			set_ext4 = edges.rise[iep_pkg::EDGE_EXT4]; // see R17
		else
			set_ext4 = fifo_engine_event; // see R16
		// pin 6 feeds the ext6 flag of the control register
		set_ext6 = edges.rise[iep_pkg::EDGE_EXT6];
	end

	// address decode of writes
	// an unmapped address matches no strobe; the write is dropped
	always_comb
	begin
		wr_ie = sfr_wr && hit(sfr_addr, iep_pkg::ADDR_IE);
		wr_ip = sfr_wr && hit(sfr_addr, iep_pkg::ADDR_IP);
		wr_xf = sfr_wr && hit(sfr_addr, iep_pkg::ADDR_XFLAGS);
		wr_xc = sfr_wr && hit(sfr_addr, iep_pkg::ADDR_XCTRL);
		wr_xe = sfr_wr && hit(sfr_addr, iep_pkg::ADDR_XEN);
		wr_xp = sfr_wr && hit(sfr_addr, iep_pkg::ADDR_XPRIO);
	end

	// sources laid out by natural priority
	always_comb
	begin
		// timer and serial flags are levels owned by their peripherals
		src_flag = '0;
		src_flag[iep_pkg::SRC_RESUME] = s_r.res_flag;
		src_flag[iep_pkg::SRC_EXT0]   = ext0_request_flag;
		src_flag[iep_pkg::SRC_TMR0]   = timer0_overflow_flag;
		src_flag[iep_pkg::SRC_EXT1]   = ext1_request_flag;
		src_flag[iep_pkg::SRC_TMR1]   = timer1_overflow_flag;
		src_flag[iep_pkg::SRC_SER0]   = serial0_tx_flag
			| serial0_rx_flag; // see R5
		src_flag[iep_pkg::SRC_TMR2]   = timer2_overflow_flag
			| timer2_external_flag; // see R4
		src_flag[iep_pkg::SRC_SER1]   = serial1_tx_flag
			| serial1_rx_flag; // see R3
		// extended flags are stored in this block
		src_flag[iep_pkg::SRC_USB]    = s_r.usb_flag;
		src_flag[iep_pkg::SRC_I2C]    = s_r.i2c_flag;
		src_flag[iep_pkg::SRC_EXT4]   = s_r.ext4_flag;
		src_flag[iep_pkg::SRC_EXT5]   = s_r.ext5_flag;
		src_flag[iep_pkg::SRC_EXT6]   = s_r.ext6_flag;
		// enable bits 6..0 line up with sources 7..1
		src_en = {s_r.xen, s_r.ie[6:0], s_r.res_en}; // see R3 R4 R5 R6 R7 R8 R9
		// resume bypasses the global enable
		src_gate = {{(N - 1){s_r.ie[iep_pkg::IE_GLOBAL_BIT]}}, 1'b1}; // see R1 R2
		// resume has no priority bit and sits in the high group
		src_high = {s_r.xprio, s_r.ip, 1'b1}; // see R10
		// a request needs its flag, its enable and its gate
		req      = src_flag & src_en & src_gate; // see R21
		req_hi   = req & src_high;
		req_lo   = req & ~src_high;
	end

	// next state: registers, sticky flags, arbitration, read data
	always_comb
	begin
		s_nxt = s_r;
		// plain control registers
		// reserved bits of a write are dropped here
		if (wr_ie)
			s_nxt.ie = sfr_wdata;
		if (wr_ip)
			s_nxt.ip = sfr_wdata[6:0];
		if (wr_xe)
			s_nxt.xen = sfr_wdata[4:0];
		if (wr_xp)
			s_nxt.xprio = sfr_wdata[4:0];
		// sticky flags: written value, then hardware set wins
		// a written one raises the request like an event would
		if (wr_xf)
		begin
			s_nxt.ext5_flag = sfr_wdata[iep_pkg::XF_EXT5_BIT]; // see R14 R15
			s_nxt.ext4_flag = sfr_wdata[iep_pkg::XF_EXT4_BIT]; // see R14 R15
			s_nxt.i2c_flag  = sfr_wdata[iep_pkg::XF_I2C_BIT]; // see R14 R15
			s_nxt.usb_flag  = sfr_wdata[iep_pkg::XF_USB_BIT]; // see R14 R15
		end
		// control: rate doubler, resume enable and flag, ext6 flag
		if (wr_xc)
		begin
			s_nxt.baud2     = sfr_wdata[iep_pkg::XC_BAUD_BIT];
			s_nxt.res_en    = sfr_wdata[iep_pkg::XC_RES_EN_BIT];
			s_nxt.res_flag  = sfr_wdata[iep_pkg::XC_RES_BIT];
			s_nxt.ext6_flag = sfr_wdata[iep_pkg::XC_EXT6_BIT];
		end
		// an event in the clearing cycle must not be lost
		if (set_ext5)
			s_nxt.ext5_flag = 1'b1; // see R13
		if (set_ext4)
			s_nxt.ext4_flag = 1'b1; // see R16 R17
		if (two_wire_bus_event)
			s_nxt.i2c_flag = 1'b1; // see R18
		if (usb_event)
			s_nxt.usb_flag = 1'b1; // see R19
		if (resume_event)
			s_nxt.res_flag = 1'b1;
		if (set_ext6)
			s_nxt.ext6_flag = 1'b1;
		// arbitration: high group first, then natural order
		// pending is the gated vector, one cycle late
		s_nxt.pend  = req;
		s_nxt.valid = |req;
		if (|req_hi)
		begin
			s_nxt.idx  = first_set(req_hi); // see R20
			s_nxt.high = 1'b1; // see R10
		end
		else if (|req_lo)
		begin
			s_nxt.idx  = first_set(req_lo); // see R20
			s_nxt.high = 1'b0;
		end
		else
		begin
			// idle: index reads zero, so the core must check valid
			s_nxt.idx  = 4'h0;
			s_nxt.high = 1'b0;
		end
		// read data; reserved bits are forced here
		// reads never touch a flag, so polling is harmless
		if (sfr_rd)
		begin
			case (sfr_addr)
				iep_pkg::ADDR_IE:
					s_nxt.rdata = s_r.ie;
				iep_pkg::ADDR_IP:
					s_nxt.rdata = iep_pkg::IP_FIXED
						| {1'b0, s_r.ip}; // see R11
				iep_pkg::ADDR_XFLAGS:
					s_nxt.rdata = iep_pkg::XFLAG_FIXED
						| {s_r.ext5_flag, s_r.ext4_flag,
						   s_r.i2c_flag, s_r.usb_flag,
						   4'h0}; // see R11 R12
				// bit 6 reads one, bits 2..0 read zero
				iep_pkg::ADDR_XCTRL:
					s_nxt.rdata = iep_pkg::XCTRL_FIXED
						| {s_r.baud2, 1'b0, s_r.res_en,
						   s_r.res_flag, s_r.ext6_flag, 3'h0};
				// bits 7..5 read one in both extended registers
				iep_pkg::ADDR_XEN:
					s_nxt.rdata = iep_pkg::XEN_FIXED
						| {3'h0, s_r.xen};
				iep_pkg::ADDR_XPRIO:
					s_nxt.rdata = iep_pkg::XPRIO_FIXED
						| {3'h0, s_r.xprio};
				// unmapped addresses read a fixed value
				default:
					s_nxt.rdata = iep_pkg::UNMAPPED_RD;
			endcase
		end
	end

	// state register with synchronous reset
	// writable fields load their reset constants; flags and
	// outputs clear with the rest of the record
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_r       <= '0;
			s_r.ie    <= iep_pkg::IE_RST;
			s_r.ip    <= iep_pkg::IP_RST;
			s_r.xen   <= iep_pkg::XEN_RST;
			s_r.xprio <= iep_pkg::XPRIO_RST;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	// no combinational path reaches a port of this block
	assign sfr_rdata           = s_r.rdata;
	assign irq_pending         = s_r.pend;
	assign irq_valid           = s_r.valid;
	assign irq_index           = s_r.idx;
	assign irq_high_group      = s_r.high;
	assign serial1_rate_double = s_r.baud2;
endmodule // iep_irq_ctrl
`default_nettype wire

// ---- design/iep_pkg.sv ----
package iep_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_XFLAGS = 8'h91; // extended_interrupt_flags
	localparam logic [7:0] ADDR_IE     = 8'hA8; // interrupt_enable
	localparam logic [7:0] ADDR_IP     = 8'hB8; // interrupt_priority
	localparam logic [7:0] ADDR_XCTRL  = 8'hD8; // extended_interrupt_control
	localparam logic [7:0] ADDR_XEN    = 8'hE8; // extended_interrupt_enable
	localparam logic [7:0] ADDR_XPRIO  = 8'hF8; // extended_interrupt_priority
	// reset values of the writable fields
	localparam logic [7:0] IE_RST    = 8'h00;
	localparam logic [6:0] IP_RST    = 7'h00;
	localparam logic [4:0] XEN_RST   = 5'h00;
	localparam logic [4:0] XPRIO_RST = 5'h00;
	// bit positions
	localparam int unsigned IE_GLOBAL_BIT = 7;  // global_irq_enable
	localparam int unsigned XF_EXT5_BIT   = 7;  // ext5_edge_flag
	localparam int unsigned XF_EXT4_BIT   = 6;  // fifo_or_ext4_flag
	localparam int unsigned XF_I2C_BIT    = 5;  // two_wire_bus_flag
	localparam int unsigned XF_USB_BIT    = 4;  // usb_event_flag
	localparam int unsigned XC_BAUD_BIT   = 7;  // serial 1 rate doubler
	localparam int unsigned XC_RES_EN_BIT = 5;  // resume enable
	localparam int unsigned XC_RES_BIT    = 4;  // resume flag
	localparam int unsigned XC_EXT6_BIT   = 3;  // ext6 flag
	// constant read-back parts of partly reserved registers
	localparam logic [7:0] IP_FIXED    = 8'h80;
	localparam logic [7:0] XFLAG_FIXED = 8'h08;
	localparam logic [7:0] XCTRL_FIXED = 8'h40;
	localparam logic [7:0] XEN_FIXED   = 8'hE0;
	localparam logic [7:0] XPRIO_FIXED = 8'hE0;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// sources, indexed by natural priority (0 wins)
	localparam int unsigned SRC_N      = 13;
	localparam int unsigned SRC_RESUME = 0;
	localparam int unsigned SRC_EXT0   = 1;
	localparam int unsigned SRC_TMR0   = 2;
	localparam int unsigned SRC_EXT1   = 3;
	localparam int unsigned SRC_TMR1   = 4;
	localparam int unsigned SRC_SER0   = 5;
	localparam int unsigned SRC_TMR2   = 6;
	localparam int unsigned SRC_SER1   = 7;
	localparam int unsigned SRC_USB    = 8;
	localparam int unsigned SRC_I2C    = 9;
	localparam int unsigned SRC_EXT4   = 10;
	localparam int unsigned SRC_EXT5   = 11;
	localparam int unsigned SRC_EXT6   = 12;
	// pin edge channels
	localparam int unsigned EDGE_N    = 3;
	localparam int unsigned EDGE_EXT5 = 0;
	localparam int unsigned EDGE_EXT4 = 1;
	localparam int unsigned EDGE_EXT6 = 2;
	// cycles after reset before a pin level is trusted
	localparam logic [1:0]  SYNC_FILL = 2'h3;
endpackage

// ---- design/iep_edge_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// raw pin levels in, one-cycle edge pulses out
interface iep_edge_if #(parameter int unsigned N = 1);
	logic [N-1:0] pin;  // raw asynchronous levels
	logic [N-1:0] rise; // one-cycle rising edge pulse
	logic [N-1:0] fall; // one-cycle falling edge pulse
	modport sync (input pin, output rise, output fall);
	modport ctrl (output pin, input rise, input fall);
endinterface
`default_nettype wire

// ---- design/iep_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module iep_edge_sync #(
	parameter int unsigned N = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pins in, edge pulses out
	iep_edge_if.sync e
);
	generate
		if (N < 1)
		begin : g_bad_n
			$error("iep_edge_sync needs at least one channel");
		end
	endgenerate

	// three stage synchroniser plus filtered level
	typedef struct packed {
		logic [N-1:0] s1;     // first stage, read by s2 only
		logic [N-1:0] s2;     // second stage
		logic [N-1:0] s3;     // third stage
		logic [N-1:0] stable; // last agreed level
		logic [1:0]   fill;   // startup counter
		logic [N-1:0] rise;   // edge pulses
		logic [N-1:0] fall;
	} iep_sync_s;

	iep_sync_s r_r;   // registered state
	iep_sync_s r_nxt; // next state

	// edge only when stages 2 and 3 agree on a new level
	always_comb
	begin
		r_nxt      = r_r;
		r_nxt.s1   = e.pin;
		r_nxt.s2   = r_r.s1;
		r_nxt.s3   = r_r.s2;
		r_nxt.rise = '0;
		r_nxt.fall = '0;
		// pins idle high at startup must not look like an edge
		if (r_r.fill != iep_pkg::SYNC_FILL)
		begin
			r_nxt.fill   = 2'(r_r.fill + 2'h1);
			r_nxt.stable = r_r.s2;
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				if (r_r.s2[i] == r_r.s3[i] && r_r.s2[i] != r_r.stable[i])
				begin
					r_nxt.stable[i] = r_r.s2[i];
					r_nxt.rise[i]   = r_r.s2[i];
					r_nxt.fall[i]   = ~r_r.s2[i];
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rstn)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign e.rise = r_r.rise;
	assign e.fall = r_r.fall;
endmodule // iep_edge_sync
`default_nettype wire

// ---- verif/iep_irq_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// watches register reads and request outputs of the controller
module iep_irq_properties (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// register port
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	// sources
	input wire logic        ext0_request_flag,
	input wire logic        timer0_overflow_flag,
	input wire logic        usb_event,
	// requests
	input wire logic [12:0] irq_pending,
	input wire logic        irq_valid,
	input wire logic [3:0]  irq_index,
	input wire logic        irq_high_group
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [7:0] ie_r; // shadow of enable register
	logic [7:0] ip_r; // shadow of priority register
	// shadows follow core writes; reads never disturb them
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ie_r <= 8'h00;
			ip_r <= 8'h00;
		end
		else if (sfr_wr && sfr_addr == iep_pkg::ADDR_IE)
			ie_r <= sfr_wdata;
		else if (sfr_wr && sfr_addr == iep_pkg::ADDR_IP)
			ip_r <= sfr_wdata;
	end
	// requests lag the register state by one edge
	AST_RD_UNMAPPED: assert property (sfr_rd && sfr_addr == 8'h00
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	AST_IP_READ: assert property (sfr_rd && sfr_addr == iep_pkg::ADDR_IP
		|=> sfr_rdata == {1'b1, $past(ip_r[6:0])})
		else $error("priority read wrong");
	AST_XF_LOW: assert property (sfr_rd && sfr_addr == iep_pkg::ADDR_XFLAGS
		|=> sfr_rdata[3:0] == 4'h8) else $error("flag reserved bits wrong");
	AST_VALID: assert property (irq_valid == (|irq_pending))
		else $error("valid disagrees with pending");
	AST_GLOBAL_OFF: assert property (!$past(ie_r[7])
		|-> irq_pending[12:1] == 12'h000) else $error("request while off");
	AST_EXT0: assert property (irq_pending[1] ==
		$past(ext0_request_flag & ie_r[0] & ie_r[7]))
		else $error("pin 0 gating wrong");
	AST_TMR0: assert property (irq_pending[2] ==
		$past(timer0_overflow_flag & ie_r[1] & ie_r[7]))
		else $error("timer 0 gating wrong");
	AST_INDEX: assert property (irq_pending[1:0] == 2'b10 &&
		irq_high_group == $past(ip_r[0]) |-> irq_index == 4'h1)
		else $error("arbitration wrong");
	AST_GROUP: assert property (irq_pending == 13'h0002
		|-> irq_high_group == $past(ip_r[0])) else $error("group wrong");
	AST_USB: assert property (usb_event ##1 !sfr_wr ##1
		(sfr_rd && sfr_addr == iep_pkg::ADDR_XFLAGS) |=> sfr_rdata[4])
		else $error("usb flag not set");
	// main scenarios reached
	COV_RESUME: cover property (!$past(ie_r[7]) && irq_pending[0]);
	COV_HIGH: cover property (irq_valid && irq_high_group);
	COV_UNMAPPED: cover property (sfr_rd && sfr_addr == 8'h00);
endmodule // iep_irq_properties
bind iep_irq_ctrl iep_irq_properties u_props (.*);
`default_nettype wire

// ---- verif/iep_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// peripheral side: flag levels, event pulses and pins
module iep_src_model (
	// clock
	input  wire logic       clk,
	// peripheral levels and one-cycle events
	output logic      [9:0] lvl,
	output logic      [3:0] ev,
	// pins and flag 6 source select
	output logic            ext5_pin_n,
	output logic            ext4_pin,
	output logic            ext6_pin,
	output logic            ext4_pin_mode
);
	// idle: pin 5 rests high as if pulled up, others low
	initial
	begin
		lvl = 10'h000;
		ev = 4'h0;
		ext5_pin_n = 1'b1;
		ext4_pin = 1'b0;
		ext6_pin = 1'b0;
		ext4_pin_mode = 1'b0;
	end
	// levels change away from the sampling edge
	task automatic set_lvl(input logic [9:0] v);
		@(negedge clk);
		lvl = v;
	endtask
	// events stay high exactly one cycle
	task automatic pulse(input logic [3:0] v);
		@(negedge clk);
		ev = v;
		@(negedge clk);
		ev = 4'h0;
	endtask
	// held long enough to clear the three-flop synchroniser
	task automatic pins(input logic p5n, input logic p4, input logic p6,
		input logic md);
		@(negedge clk);
		ext4_pin_mode = md;
		ext5_pin_n = p5n;
		ext4_pin = p4;
		ext6_pin = p6;
		repeat (8) @(negedge clk);
	endtask
endmodule // iep_src_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, rstn, sfr_wr, sfr_rd;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic [9:0]  lvl;       // peripheral levels from the model
	logic [3:0]  ev;        // usb, two wire, fifo, resume
	logic        ext4_pin_mode, ext5_pin_n, ext4_pin, ext6_pin;
	logic [12:0] irq_pending;
	logic [3:0]  irq_index;
	logic        irq_valid, irq_high_group, serial1_rate_double;
	wire         ext0_request_flag, ext1_request_flag, timer0_overflow_flag;
	wire         timer1_overflow_flag, timer2_overflow_flag;
	wire         timer2_external_flag, serial0_tx_flag, serial0_rx_flag;
	wire         serial1_tx_flag, serial1_rx_flag, usb_event;
	wire         two_wire_bus_event, fifo_engine_event, resume_event;
	int          err_total, total_checks;
	assign {ext0_request_flag, ext1_request_flag, timer0_overflow_flag,
		timer1_overflow_flag, timer2_overflow_flag, timer2_external_flag,
		serial0_tx_flag, serial0_rx_flag, serial1_tx_flag,
		serial1_rx_flag} = lvl;
	assign {usb_event, two_wire_bus_event, fifo_engine_event,
		resume_event} = ev;
	iep_irq_ctrl uut (.*);
	iep_src_model src (.*);
	// free-running core clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// write strobe lasts one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	// data is settled one cycle after the read edge
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk({12'h000, sfr_rdata}, {12'h000, e});
	endtask
	// requests settle two edges after the cause
	task automatic irqc(input logic [12:0] p, input logic [3:0] i,
		input logic h);
		repeat (2) @(negedge clk);
		chk({1'b0, irq_valid, irq_high_group, irq_index, irq_pending},
			{1'b0, |p, h, i, p});
	endtask
	task automatic t_regs;
		rdc(iep_pkg::ADDR_XFLAGS, 8'h08);
		rdc(8'h00, 8'h00);
		rdc(iep_pkg::ADDR_IE, 8'h00);
		wr(iep_pkg::ADDR_IP, 8'h7F);
		rdc(iep_pkg::ADDR_IP, 8'hFF);
		wr(iep_pkg::ADDR_XFLAGS, 8'h0F);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h08);
		wr(iep_pkg::ADDR_IP, 8'h00);
		$display("t_regs finished");
	endtask
	// two patterns so each either-flag source is seen alone
	task automatic t_gate;
		for (int k = 0; k < 2; k++)
		begin
			src.set_lvl(k ? 10'h3D5 : 10'h3EA);
			wr(iep_pkg::ADDR_IE, 8'h7F);
			irqc(13'h0000, 4'h0, 1'b0);
			for (int i = 0; i < 7; i++)
			begin
				wr(iep_pkg::ADDR_IE, 8'h80 | (8'h01 << i));
				irqc(13'h0002 << i, 4'(i + 1), 1'b0);
			end
		end
		wr(iep_pkg::ADDR_IE, 8'hFF);
		wr(iep_pkg::ADDR_IP, 8'h40);
		irqc(13'h00FE, 4'h7, 1'b1);
		wr(iep_pkg::ADDR_IP, 8'h00);
		irqc(13'h00FE, 4'h1, 1'b0);
		src.set_lvl(10'h000);
		$display("t_gate finished");
	endtask
	task automatic t_flags;
		wr(iep_pkg::ADDR_IE, 8'h80);
		wr(iep_pkg::ADDR_XEN, 8'h1F);
		rdc(iep_pkg::ADDR_XEN, 8'hFF);
		src.pulse(4'h8);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h18);
		irqc(13'h0100, 4'h8, 1'b0);
		wr(iep_pkg::ADDR_XPRIO, 8'h01);
		irqc(13'h0100, 4'h8, 1'b1);
		rdc(iep_pkg::ADDR_XPRIO, 8'hE1);
		wr(iep_pkg::ADDR_XPRIO, 8'h00);
		wr(iep_pkg::ADDR_XFLAGS, 8'h00);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h08);
		src.pulse(4'h4);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h28);
		src.pulse(4'h2);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h68);
		wr(iep_pkg::ADDR_XFLAGS, 8'h80);
		irqc(13'h0800, 4'hB, 1'b0);
		wr(iep_pkg::ADDR_XFLAGS, 8'h00);
		src.pins(1'b0, 1'b0, 1'b0, 1'b1);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h88);
		src.pins(1'b1, 1'b1, 1'b1, 1'b1);
		rdc(iep_pkg::ADDR_XFLAGS, 8'hC8);
		rdc(iep_pkg::ADDR_XCTRL, 8'h48);
		wr(iep_pkg::ADDR_XFLAGS, 8'h00);
		wr(iep_pkg::ADDR_XCTRL, 8'h80);
		chk({19'h00000, serial1_rate_double}, 20'h00001);
		rdc(iep_pkg::ADDR_XCTRL, 8'hC0);
		src.pulse(4'h2);
		rdc(iep_pkg::ADDR_XFLAGS, 8'h08);
		$display("t_flags finished");
	endtask
	// resume passes with the global enable off
	task automatic t_res;
		wr(iep_pkg::ADDR_IE, 8'h00);
		wr(iep_pkg::ADDR_XCTRL, 8'h20);
		src.pulse(4'h1);
		irqc(13'h0001, 4'h0, 1'b1);
		wr(iep_pkg::ADDR_XCTRL, 8'h00);
		irqc(13'h0000, 4'h0, 1'b0);
		$display("t_res finished");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		err_total = 0;
		total_checks = 0;
		rstn = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		t_regs;
		t_gate;
		t_flags;
		t_res;
		stop_test;
	end
	// tests need well under a thousand cycles
	initial
	begin
		#100000;
		err_total++;
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
